// >>> core/ppc_map.svh
// Field positions, reset values and timing counts for the port 3..6 pin control
`ifndef PPC_MAP_SVH
`define PPC_MAP_SVH
// Direction bit 1 means input; every pin is an input after reset
`define PPC_DIR_RESET     8'hff
// Pull-up select fields, one bit per port
`define PPC_PU_P3         0
`define PPC_PU_P4         1
`define PPC_PU_P5         2
`define PPC_PU_P6         3
// Bus expansion fields
`define PPC_BX_P4_IN      0
`define PPC_BX_EXP_EN     1
`define PPC_BX_WAIT_EN    2
`define PPC_BX_RESET      3'h1
// Port 3 alternate positions
`define PPC_P3_TA_IN      3
`define PPC_P3_TB_IN      4
`define PPC_P3_CLK_OUT    5
`define PPC_P3_TONE_OUT   6
// Port 6 control positions
`define PPC_P6_RD         4
`define PPC_P6_WR         5
`define PPC_P6_WAIT       6
`define PPC_P6_ADDRESS_LATCH_STROBE       7
// Strobe width: least time in ns, period in ns, cycles rounded up
`define PPC_CLK_NS        4
`define PPC_STRB_NS       16
`define PPC_STRB_CYC      ((`PPC_STRB_NS + `PPC_CLK_NS - 1) / `PPC_CLK_NS)
`endif

// >>> core/ppc_pin_ctrl.sv
// Port 3..6 pin control with external memory expansion sequencer
`include "ppc_map.svh"

// Summary of operation
// - Port 3 direction chosen per bit
// - Port 3 inputs pulled up when selected
// - Port 3 carries timer, clock, tone functions
// - Port 4 direction set as whole byte
// - Port 4 falling edge sets flag in port input mode
// - Port 4 input pull-ups follow select
// - Expansion: port 4 muxed bus, no pull-ups
// - Port 5 direction chosen per bit
// - Port 5 inputs pulled up when selected
// - Expansion: port 5 high address, no pull-ups
// - Port 6 direction chosen per bit
// - Port 6 low nibble open-drain only
// - Port 6 upper inputs pulled up when selected
// - Expansion: port 6 carries bus strobes
// - Unused wait pin stays ordinary port
// - Address latch strobe precedes data phase
module ppc_pin_ctrl (
    // Clock, reset, enable
    input  wire logic        clock_i,
    input  wire logic        sys_rst_i,
    input  wire logic        ce_i,
    // Configuration
    input  wire logic [7:0]  port3_direction_i,
    input  wire logic [7:0]  port5_direction_i,
    input  wire logic [7:0]  port6_direction_i,
    input  wire logic [2:0]  bus_expansion_i,
    input  wire logic [3:0]  pull_resistor_select_i,
    input  wire logic [7:0]  port3_alt_sel_i,
    // Output latches
    input  wire logic [7:0]  port3_latch_i,
    input  wire logic [7:0]  port4_latch_i,
    input  wire logic [7:0]  port5_latch_i,
    input  wire logic [7:0]  port6_latch_i,
    // Alternate function sources and sinks
    input  wire logic [2:0]  timer_out_pins_i,
    input  wire logic        clock_out_pin_i,
    input  wire logic        tone_output_i,
    output logic             timer_a_count_input_o,
    output logic             timer_b_count_input_o,
    // External access request
    input  wire logic        bus_req_i,
    input  wire logic        bus_write_i,
    input  wire logic [15:0] bus_addr_i,
    input  wire logic [7:0]  bus_wdata_i,
    output logic             bus_busy_o,
    output logic             bus_done_o,
    output logic [7:0]       bus_rdata_o,
    // Edge flag
    input  wire logic        port4_fall_clear_i,
    output logic             port4_fall_flag_o,
    // Pins
    input  wire logic [7:0]  port3_pins_i,
    output logic [7:0]       port3_pins_o,
    output logic [7:0]       port3_pins_oe_o,
    output logic [7:0]       port3_pullup_o,
    input  wire logic [7:0]  port4_pins_i,
    output logic [7:0]       port4_pins_o,
    output logic [7:0]       port4_pins_oe_o,
    output logic [7:0]       port4_pullup_o,
    input  wire logic [7:0]  port5_pins_i,
    output logic [7:0]       port5_pins_o,
    output logic [7:0]       port5_pins_oe_o,
    output logic [7:0]       port5_pullup_o,
    input  wire logic [7:0]  port6_pins_i,
    output logic [7:0]       port6_pins_o,
    output logic [7:0]       port6_pins_oe_o,
    output logic [7:0]       port6_pullup_o,
    // Read-back values
    output logic [7:0]       port3_read_o,
    output logic [7:0]       port4_read_o,
    output logic [7:0]       port5_read_o,
    output logic [7:0]       port6_read_o
);
    // Configuration registers
    logic [7:0]          port3_direction_reg;
    logic [7:0]          port5_direction_reg;
    logic [7:0]          port6_direction_reg;
    logic [2:0]          bus_expansion_reg;
    logic [3:0]          pull_resistor_select;
    // Pin synchronisers, all four ports packed
    logic [31:0]         sync1_reg;
    logic [31:0]         sync2_reg;
    logic [31:0]         sync3_reg;
    logic [31:0]         stable_reg;
    logic [31:0]         stable_next;
    // Sequencer
    ppc_pkg::ppc_state_e state_reg;
    logic [15:0]         addr_reg;
    logic [7:0]          wdata_reg;
    logic                write_reg;
    logic [2:0]          strb_cnt_reg;
    // Pin drive next values
    logic [7:0]          p3_out_next, p3_oe_next, p3_pu_next;
    logic [7:0]          p4_out_next, p4_oe_next, p4_pu_next;
    logic [7:0]          p5_out_next, p5_oe_next, p5_pu_next;
    logic [7:0]          p6_out_next, p6_oe_next, p6_pu_next;
    logic                exp_en;
    logic                wait_en;
    logic                wait_hold;
    logic                p4_fall;

    assign exp_en    = bus_expansion_reg[`PPC_BX_EXP_EN];
    assign wait_en   = exp_en & bus_expansion_reg[`PPC_BX_WAIT_EN];
    // Wait pin is active low; settling value used so a wait raised at strobe start is caught
    assign wait_hold = wait_en & ~stable_next[24 + `PPC_P6_WAIT];
    // Fall detect only in port input mode, on a settled change
    assign p4_fall   = ~exp_en & bus_expansion_reg[`PPC_BX_P4_IN]
                       & |(stable_reg[15:8] & ~stable_next[15:8]);

    // Per-byte read-back: pin level for inputs, latch for outputs
    function automatic ppc_pkg::ppc_byte_t read_mux(input logic [7:0] dir,
                                                     input logic [7:0] pin,
                                                     input logic [7:0] latch);
        read_mux = (dir & pin) | (~dir & latch);
    endfunction

    // Configuration capture; reset makes every pin an input
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            port3_direction_reg  <= `PPC_DIR_RESET;
            port5_direction_reg  <= `PPC_DIR_RESET;
            port6_direction_reg  <= `PPC_DIR_RESET;
            bus_expansion_reg    <= `PPC_BX_RESET;
            pull_resistor_select <= 4'h0;
        end else if (ce_i) begin
            port3_direction_reg  <= port3_direction_i;
            port5_direction_reg  <= port5_direction_i;
            port6_direction_reg  <= port6_direction_i;
            bus_expansion_reg    <= bus_expansion_i;
            pull_resistor_select <= pull_resistor_select_i;
        end
    end

    // Settled value: a change counts when stages two and three agree
    always_comb begin
        stable_next = (sync2_reg & sync3_reg) | (stable_reg & (sync2_reg ^ sync3_reg));
    end

    // Three-stage pin synchroniser; stage one feeds stage two only
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            sync1_reg  <= 32'h0;
            sync2_reg  <= 32'h0;
            sync3_reg  <= 32'h0;
            stable_reg <= 32'h0;
        end else if (ce_i) begin
            sync1_reg  <= {port6_pins_i, port5_pins_i, port4_pins_i, port3_pins_i};
            sync2_reg  <= sync1_reg;
            sync3_reg  <= sync2_reg;
            stable_reg <= stable_next;
        end
    end

    // Edge flag; a new edge wins over a clear in the same cycle
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            port4_fall_flag_o <= 1'b0;
        end else if (ce_i) begin
            if (p4_fall) begin
                port4_fall_flag_o <= 1'b1;
            end else if (port4_fall_clear_i) begin
                port4_fall_flag_o <= 1'b0;
            end
        end
    end

    // External access sequencer: address phase, strobe phase, done
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            state_reg    <= ppc_pkg::PPC_IDLE;
            addr_reg     <= 16'h0;
            wdata_reg    <= 8'h0;
            write_reg    <= 1'b0;
            strb_cnt_reg <= 3'h0;
            bus_done_o   <= 1'b0;
            bus_busy_o   <= 1'b0;
            bus_rdata_o  <= 8'h0;
        end else if (ce_i) begin
            bus_done_o <= 1'b0;
            case (state_reg)
                ppc_pkg::PPC_IDLE: begin
                    // Requests outside expansion mode are ignored
                    if (bus_req_i && exp_en) begin
                        state_reg  <= ppc_pkg::PPC_ADDR;
                        addr_reg   <= bus_addr_i;
                        wdata_reg  <= bus_wdata_i;
                        write_reg  <= bus_write_i;
                        bus_busy_o <= 1'b1;
                    end
                end
                ppc_pkg::PPC_ADDR: begin
                    // Address latched externally before strobes move
                    state_reg    <= ppc_pkg::PPC_STRB;
                    // One spare strobe cycle covers the pin synchroniser lag
                    strb_cnt_reg <= 3'(`PPC_STRB_CYC);
                end
                ppc_pkg::PPC_STRB: begin
                    if (strb_cnt_reg != 3'h0) begin
                        strb_cnt_reg <= strb_cnt_reg - 3'h1;
                    end else if (!wait_hold) begin
                        // Strobe ends only once wait is released
                        state_reg   <= ppc_pkg::PPC_DONE;
                        bus_rdata_o <= stable_next[15:8];
                    end
                end
                ppc_pkg::PPC_DONE: begin
                    state_reg  <= ppc_pkg::PPC_IDLE;
                    bus_done_o <= 1'b1;
                    bus_busy_o <= 1'b0;
                end
                default: state_reg <= ppc_pkg::PPC_IDLE;
            endcase
        end
    end

    // Pin drive decode for all four ports
    always_comb begin
        // Port 3: per-bit direction, alternate outputs on chosen bits
        p3_oe_next  = ~port3_direction_reg;
        p3_out_next = port3_latch_i;
        if (port3_alt_sel_i[0]) p3_out_next[0] = timer_out_pins_i[0];
        if (port3_alt_sel_i[1]) p3_out_next[1] = timer_out_pins_i[1];
        if (port3_alt_sel_i[2]) p3_out_next[2] = timer_out_pins_i[2];
        if (port3_alt_sel_i[`PPC_P3_CLK_OUT])  p3_out_next[`PPC_P3_CLK_OUT]  = clock_out_pin_i;
        if (port3_alt_sel_i[`PPC_P3_TONE_OUT]) p3_out_next[`PPC_P3_TONE_OUT] = tone_output_i;
        p3_pu_next  = {8{pull_resistor_select[`PPC_PU_P3]}} & port3_direction_reg;
        // Port 4 and 5 in port mode
        p4_oe_next  = {8{~bus_expansion_reg[`PPC_BX_P4_IN]}};
        p4_out_next = port4_latch_i;
        p4_pu_next  = {8{pull_resistor_select[`PPC_PU_P4]}} & ~p4_oe_next;
        p5_oe_next  = ~port5_direction_reg;
        p5_out_next = port5_latch_i;
        p5_pu_next  = {8{pull_resistor_select[`PPC_PU_P5]}} & port5_direction_reg;
        // Port 6: low nibble only pulls low, upper nibble push-pull
        p6_oe_next  = ~port6_direction_reg & {4'hf, ~port6_latch_i[3:0]};
        p6_out_next = {port6_latch_i[7:4], 4'h0};
        p6_pu_next  = {{4{pull_resistor_select[`PPC_PU_P6]}} & port6_direction_reg[7:4], 4'h0};
        if (exp_en) begin
            // Muxed bus: address in ADDR, write data later, else released
            p4_out_next = (state_reg == ppc_pkg::PPC_ADDR) ? addr_reg[7:0] : wdata_reg;
            p4_oe_next  = {8{(state_reg == ppc_pkg::PPC_ADDR)
                          | ((state_reg == ppc_pkg::PPC_STRB) & write_reg)}};
            p4_pu_next  = 8'h00;
            p5_out_next = addr_reg[15:8];
            p5_oe_next  = 8'hff;
            p5_pu_next  = 8'h00;
            // Control strobes; read and write are active low
            p6_out_next[`PPC_P6_RD]   = ~((state_reg == ppc_pkg::PPC_STRB) & ~write_reg);
            p6_out_next[`PPC_P6_WR]   = ~((state_reg == ppc_pkg::PPC_STRB) & write_reg);
            p6_out_next[`PPC_P6_ADDRESS_LATCH_STROBE] = (state_reg == ppc_pkg::PPC_ADDR);
            p6_oe_next[`PPC_P6_RD]    = 1'b1;
            p6_oe_next[`PPC_P6_WR]    = 1'b1;
            p6_oe_next[`PPC_P6_ADDRESS_LATCH_STROBE]  = 1'b1;
            p6_pu_next[`PPC_P6_RD]    = 1'b0;
            p6_pu_next[`PPC_P6_WR]    = 1'b0;
            p6_pu_next[`PPC_P6_ADDRESS_LATCH_STROBE]  = 1'b0;
            // Without wait the pin keeps its port role
            if (wait_en) begin
                p6_oe_next[`PPC_P6_WAIT] = 1'b0;
                p6_pu_next[`PPC_P6_WAIT] = 1'b0;
            end
        end
    end

    // Registered pin drives, pull-ups, count inputs and read-back
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            port3_pins_o          <= 8'h00;
            port3_pins_oe_o       <= 8'h00;
            port3_pullup_o        <= 8'h00;
            port4_pins_o          <= 8'h00;
            port4_pins_oe_o       <= 8'h00;
            port4_pullup_o        <= 8'h00;
            port5_pins_o          <= 8'h00;
            port5_pins_oe_o       <= 8'h00;
            port5_pullup_o        <= 8'h00;
            port6_pins_o          <= 8'h00;
            port6_pins_oe_o       <= 8'h00;
            port6_pullup_o        <= 8'h00;
            timer_a_count_input_o <= 1'b0;
            timer_b_count_input_o <= 1'b0;
            port3_read_o          <= 8'h00;
            port4_read_o          <= 8'h00;
            port5_read_o          <= 8'h00;
            port6_read_o          <= 8'h00;
        end else if (ce_i) begin
            port3_pins_o          <= p3_out_next;
            port3_pins_oe_o       <= p3_oe_next;
            port3_pullup_o        <= p3_pu_next;
            port4_pins_o          <= p4_out_next;
            port4_pins_oe_o       <= p4_oe_next;
            port4_pullup_o        <= p4_pu_next;
            port5_pins_o          <= p5_out_next;
            port5_pins_oe_o       <= p5_oe_next;
            port5_pullup_o        <= p5_pu_next;
            port6_pins_o          <= p6_out_next;
            port6_pins_oe_o       <= p6_oe_next;
            port6_pullup_o        <= p6_pu_next;
            // Count inputs gated by their alternate select
            timer_a_count_input_o <= port3_alt_sel_i[`PPC_P3_TA_IN]
                                     & stable_reg[`PPC_P3_TA_IN];
            timer_b_count_input_o <= port3_alt_sel_i[`PPC_P3_TB_IN]
                                     & stable_reg[`PPC_P3_TB_IN];
            port3_read_o <= read_mux(port3_direction_reg, stable_reg[7:0], port3_latch_i);
            port4_read_o <= read_mux({8{bus_expansion_reg[`PPC_BX_P4_IN]}},
                                     stable_reg[15:8], port4_latch_i);
            port5_read_o <= read_mux(port5_direction_reg, stable_reg[23:16], port5_latch_i);
            port6_read_o <= read_mux(port6_direction_reg, stable_reg[31:24], port6_latch_i);
        end
    end

    // Port 3 drive follows its direction bits
    p3_dir_follow_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        ce_i |=> port3_pins_oe_o == ~$past(port3_direction_reg))
        else $error("port 3 enable does not follow direction");
    p3_pullup_sel_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        ce_i |=> port3_pullup_o == ($past(port3_direction_reg)
                 & {8{$past(pull_resistor_select[`PPC_PU_P3])}}))
        else $error("port 3 pull-up wrong");
    p4_byte_dir_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        port4_pins_oe_o == 8'h00 || port4_pins_oe_o == 8'hff)
        else $error("port 4 direction split");
    p4_fall_set_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        ce_i && p4_fall |=> port4_fall_flag_o)
        else $error("port 4 fall edge lost");
    exp_pullup_off_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        ce_i && exp_en |=> port4_pullup_o == 8'h00 && port5_pullup_o == 8'h00)
        else $error("pull-up on in expansion mode");
    p6_open_drain_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        (port6_pins_oe_o[3:0] & port6_pins_o[3:0]) == 4'h0)
        else $error("port 6 low nibble driven high");
    address_latch_strobe_before_rd_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        exp_en && $fell(port6_pins_o[`PPC_P6_RD]) |-> $past(port6_pins_o[`PPC_P6_ADDRESS_LATCH_STROBE]))
        else $error("read strobe without address latch");
    strobe_width_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        exp_en && $fell(port6_pins_o[`PPC_P6_RD]) |-> !port6_pins_o[`PPC_P6_RD] [*4])
        else $error("read strobe too short");
    reset_inputs_a: assert property (@(posedge clock_i)
        sys_rst_i |=> port3_pins_oe_o == 8'h00
        && port4_pins_oe_o == 8'h00 && port6_pins_oe_o == 8'h00)
        else $error("pin driven during reset");
endmodule

// >>> core/ppc_pkg.sv
// Types for the port 3..6 pin control
package ppc_pkg;
    // External access sequencer states
    typedef enum logic [1:0] {
        PPC_IDLE = 2'b00,
        PPC_ADDR = 2'b01,
        PPC_STRB = 2'b10,
        PPC_DONE = 2'b11
    } ppc_state_e;
    typedef logic [7:0] ppc_byte_t;
endpackage

// >>> dv/ppc_ext_mem.sv
// Behavioural external memory on the expansion bus, with optional wait stretching
module ppc_ext_mem (
    // Clock
    input  wire logic        clock_i,
    // Bus pins as driven by the device
    input  wire logic [7:0]  p4_out_i,
    input  wire logic [7:0]  p5_out_i,
    input  wire logic [7:0]  p6_out_i,
    input  wire logic [7:0]  p6_oe_i,
    // Slow mode asks for wait states
    input  wire logic        slow_i,
    // Responses towards the pins
    output logic [7:0]       rdata_o,
    output logic             rdata_oe_o,
    output logic             wait_n_o,
    output logic [15:0]      last_addr_o
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] mem [0:65535];  // Whole 64K space
    logic       rd_n;           // Strobes read high once the device lets go
    logic       wr_n;
    logic       address_latch_strobe;
    int         stall = 0;      // Cycles elapsed in this strobe
    assign rd_n = ~(p6_oe_i[4] & ~p6_out_i[4]);
    assign wr_n = ~(p6_oe_i[5] & ~p6_out_i[5]);
    assign address_latch_strobe = p6_oe_i[7] & p6_out_i[7];
    // Data only while read strobe is low, else line released
    assign rdata_oe_o = ~rd_n;
    assign rdata_o = mem[last_addr_o];
    // Six cycles of wait per strobe in slow mode
    assign wait_n_o = ~(slow_i & ~(rd_n & wr_n) & (stall < 6));
    initial begin
        foreach (mem[i]) mem[i] = 8'h00;
        last_addr_o = 16'h0000;
    end
    // Address capture on the latch strobe, data capture under write strobe
    always @(posedge clock_i) begin
        if (address_latch_strobe) last_addr_o <= {p5_out_i, p4_out_i};
        if (!wr_n) mem[last_addr_o] <= p4_out_i;
        stall <= (rd_n & wr_n) ? 0 : stall + 1;
    end
endmodule

// >>> dv/test_port3_to_port6_pin_control.sv
// Self-checking bench for the port 3..6 pin control
module test_port3_to_port6_pin_control;
    timeunit 1ns;
    timeprecision 100ps;
    // One ordinary configuration and the pin state it should give
    typedef struct {
        logic [7:0] dir, lat; logic [2:0] bx; logic [3:0] pu;
        logic [7:0] oe3, oe4, oe6, pu3, pu4, pu6;
    } ppc_row_s;
    // Stimulus, direction shared by ports 3, 5, 6, latch shared by all four ports
    logic        clock_i = 1'b0;
    logic        sys_rst_i = 1'b1;
    logic        ce_i = 1'b1;
    logic [7:0]  dir = 8'hff, lat = 8'h00, alt = 8'h00, ext3 = 8'h00, ext4 = 8'h00;
    logic [2:0]  bx = 3'h1, tout = 3'h0;
    logic [3:0]  pu = 4'hf;
    logic        clko = 1'b0, tone = 1'b0, req = 1'b0, wr = 1'b0, fclr = 1'b0, slow = 1'b0;
    logic [15:0] addr = 16'h0000, m_addr;
    logic [7:0]  wdata = 8'h00, rdata, rd, m_dat, read3, read4, read5, read6;
    logic        ta, tb, busy, done, flag, m_oe, m_wait_n;
    logic [7:0]  p3i, p3o, p3e, p3u, p4i, p4o, p4e, p4u, p5i, p5o, p5e, p5u, p6i, p6o, p6e, p6u;
    int          failures = 0, n_tests = 0, c0, c1;
    ppc_row_s rows [3] = '{
        '{8'h0f, 8'h5a, 3'h1, 4'hf, 8'hf0, 8'h00, 8'hf0, 8'h0f, 8'hff, 8'h00},
        '{8'hf0, 8'h5a, 3'h0, 4'h5, 8'h0f, 8'hff, 8'h05, 8'hf0, 8'h00, 8'h00},
        '{8'h3c, 8'hc3, 3'h1, 4'ha, 8'hc3, 8'h00, 8'hc0, 8'h00, 8'hff, 8'h30}};
    // Wire levels: device where it drives, else memory or outside drivers
    assign p3i = (p3e & p3o) | (~p3e & ext3);
    assign p4i = (p4e & p4o) | (~p4e & (m_oe ? m_dat : ext4));
    assign p5i = (p5e & p5o) | (~p5e & ext3);
    assign p6i = (p6e & p6o) | (~p6e & {ext3[7], m_wait_n, ext3[5:0]});
    ppc_pin_ctrl DUT (
        .clock_i(clock_i), .sys_rst_i(sys_rst_i), .ce_i(ce_i),
        .port3_direction_i(dir), .port5_direction_i(dir), .port6_direction_i(dir),
        .bus_expansion_i(bx), .pull_resistor_select_i(pu), .port3_alt_sel_i(alt),
        .port3_latch_i(lat), .port4_latch_i(lat), .port5_latch_i(lat), .port6_latch_i(lat),
        .timer_out_pins_i(tout), .clock_out_pin_i(clko), .tone_output_i(tone),
        .timer_a_count_input_o(ta), .timer_b_count_input_o(tb),
        .bus_req_i(req), .bus_write_i(wr), .bus_addr_i(addr), .bus_wdata_i(wdata),
        .bus_busy_o(busy), .bus_done_o(done), .bus_rdata_o(rdata),
        .port4_fall_clear_i(fclr), .port4_fall_flag_o(flag),
        .port3_pins_i(p3i), .port3_pins_o(p3o), .port3_pins_oe_o(p3e), .port3_pullup_o(p3u),
        .port4_pins_i(p4i), .port4_pins_o(p4o), .port4_pins_oe_o(p4e), .port4_pullup_o(p4u),
        .port5_pins_i(p5i), .port5_pins_o(p5o), .port5_pins_oe_o(p5e), .port5_pullup_o(p5u),
        .port6_pins_i(p6i), .port6_pins_o(p6o), .port6_pins_oe_o(p6e), .port6_pullup_o(p6u),
        .port3_read_o(read3), .port4_read_o(read4), .port5_read_o(read5),
        .port6_read_o(read6));
    ppc_ext_mem mem_model (
        .clock_i(clock_i), .p4_out_i(p4o), .p5_out_i(p5o), .p6_out_i(p6o), .p6_oe_i(p6e),
        .slow_i(slow), .rdata_o(m_dat), .rdata_oe_o(m_oe), .wait_n_o(m_wait_n),
        .last_addr_o(m_addr));
    // 250 MHz clock
    always #2 clock_i = ~clock_i;
    // Byte comparison, single bits zero-extended
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Let edges pass, then look once updates have landed
    task automatic settle(input int n);
        repeat (n) @(posedge clock_i);
        #1;
    endtask
    // One external access; request held until busy is seen at an edge
    task automatic bus_op(input logic w, input logic [15:0] a, input logic [7:0] d,
                          output logic [7:0] r, output int cyc);
        @(posedge clock_i);
        req <= 1'b1;
        wr <= w;
        addr <= a;
        wdata <= d;
        for (cyc = 0; cyc < 40 && busy !== 1'b1; cyc++) @(posedge clock_i);
        req <= 1'b0;
        for (cyc = 0; cyc < 60 && done !== 1'b1; cyc++) @(posedge clock_i);
        r = rdata;
        chk("access done", 8'h01, {7'h0, done});
    endtask
    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // Watchdog, far beyond the fewer than two hundred cycles the tests need
    initial begin
        repeat (5000) @(posedge clock_i);
        failures++;
        tally_and_finish();
    end
    initial begin
        // Reset held by the outside for five cycles
        repeat (5) @(posedge clock_i);
        sys_rst_i <= 1'b0;
        settle(1);
        chk("reset oe", 8'h00, p3e | p4e | p5e | p6e);
        chk("reset pull", 8'h00, p3u | p4u | p5u | p6u);
        chk("reset busy flag", 8'h00, {6'h0, busy, flag});
        $display("test reset done");
        // Ordinary port-mode configurations
        foreach (rows[i]) begin
            @(posedge clock_i);
            dir <= rows[i].dir;
            lat <= rows[i].lat;
            bx <= rows[i].bx;
            pu <= rows[i].pu;
            ext3 <= ~rows[i].lat;
            ext4 <= ~rows[i].lat;
            settle(10);
            chk("p3 oe", rows[i].oe3, p3e);
            chk("p5 oe", rows[i].oe3, p5e);
            chk("p4 oe", rows[i].oe4, p4e);
            chk("p6 oe", rows[i].oe6, p6e);
            chk("p3 pull", rows[i].pu3, p3u);
            chk("p5 pull", rows[i].pu3, p5u);
            chk("p4 pull", rows[i].pu4, p4u);
            chk("p6 pull", rows[i].pu6, p6u);
            chk("p3 drive", rows[i].lat & rows[i].oe3, p3o & p3e);
            chk("p4 drive", rows[i].lat & rows[i].oe4, p4o & p4e);
            chk("p6 low drive", 8'h00, p6o & 8'h0f);
            chk("p3 read", rows[i].lat ^ ~rows[i].oe3, read3);
            chk("p5 read", rows[i].lat ^ ~rows[i].oe3, read5);
            chk("p4 read", rows[i].lat ^ ~rows[i].oe4, read4);
            // Bit 6 input sees the idle wait line, so it is left out here
            chk("p6 read", (rows[i].lat ^ ~rows[i].oe3) & 8'hbf, read6 & 8'hbf);
        end
        $display("test rows done");
        // Port 3 alternate functions both ways
        @(posedge clock_i);
        bx <= 3'h1;
        dir <= 8'h98;
        alt <= 8'h7f;
        tout <= 3'b101;
        clko <= 1'b1;
        ext3 <= 8'h08;
        settle(10);
        chk("alt oe", 8'h67, p3e & 8'h67);
        chk("alt out", 8'h25, p3o & 8'h67);
        chk("count inputs", 8'h01, {6'h0, tb, ta});
        @(posedge clock_i);
        ext3 <= 8'h10;
        tone <= 1'b1;
        settle(10);
        chk("tone out", 8'h40, p3o & 8'h40);
        chk("count inputs", 8'h02, {6'h0, tb, ta});
        $display("test alternate done");
        // Falling edge flag: quiet, one falling bit, then clear
        @(posedge clock_i);
        alt <= 8'h00;
        ext4 <= 8'hff;
        fclr <= 1'b1;
        settle(10);
        @(posedge clock_i);
        fclr <= 1'b0;
        settle(3);
        chk("flag idle", 8'h00, {7'h0, flag});
        @(posedge clock_i);
        ext4 <= 8'hfe;
        settle(10);
        chk("flag set", 8'h01, {7'h0, flag});
        @(posedge clock_i);
        fclr <= 1'b1;
        @(posedge clock_i);
        fclr <= 1'b0;
        settle(3);
        chk("flag cleared", 8'h00, {7'h0, flag});
        $display("test edge flag done");
        // Expansion write and read, spare wait pin used as a port
        @(posedge clock_i);
        bx <= 3'h2;
        pu <= 4'hf;
        dir <= 8'hbf;
        lat <= 8'h40;
        settle(3);
        bus_op(1'b1, 16'h12a5, 8'h3c, rd, c0);
        chk("latched address", 8'h12, m_addr[15:8]);
        chk("latched address", 8'ha5, m_addr[7:0]);
        bus_op(1'b0, 16'h12a5, 8'h00, rd, c0);
        chk("read data", 8'h3c, rd);
        chk("p4 pull", 8'h00, p4u);
        chk("p5 pull", 8'h00, p5u);
        chk("strobe pull", 8'h00, p6u & 8'hb0);
        chk("spare wait oe", 8'h40, p6e & 8'h40);
        chk("spare wait out", 8'h40, p6o & 8'h40);
        // Same read stretched by the memory's wait
        @(posedge clock_i);
        bx <= 3'h6;
        slow <= 1'b1;
        settle(3);
        bus_op(1'b0, 16'h12a5, 8'h00, rd, c1);
        chk("stretched read", 8'h3c, rd);
        chk("stretched longer", 8'h01, {7'h0, c1 > c0});
        $display("test expansion done");
        // Request with expansion off is ignored
        @(posedge clock_i);
        bx <= 3'h1;
        slow <= 1'b0;
        settle(3);
        @(posedge clock_i);
        req <= 1'b1;
        repeat (10) begin
            @(posedge clock_i);
            chk("busy while off", 8'h00, {7'h0, busy});
        end
        req <= 1'b0;
        $display("test refused done");
        // Second reset with outputs configured
        @(posedge clock_i);
        dir <= 8'h00;
        sys_rst_i <= 1'b1;
        settle(3);
        chk("oe in reset", 8'h00, p3e | p5e | p6e);
        @(posedge clock_i);
        sys_rst_i <= 1'b0;
        settle(1);
        chk("oe after reset", 8'h00, p3e | p5e | p6e);
        $display("test second reset done");
        tally_and_finish();
    end
endmodule
